// file: src/debug_port_defs.vh
`ifndef DEBUG_PORT_DEFS_VH
`define DEBUG_PORT_DEFS_VH
`define TAP_RESET      4'h0
`define TAP_IDLE       4'h1
`define TAP_SEL_DR     4'h2
`define TAP_CAP_DR     4'h3
`define TAP_SHIFT_DR   4'h4
`define TAP_EXIT1_DR   4'h5
`define TAP_PAUSE_DR   4'h6
`define TAP_EXIT2_DR   4'h7
`define TAP_UPD_DR     4'h8
`define TAP_SEL_IR     4'h9
`define TAP_CAP_IR     4'hA
`define TAP_SHIFT_IR   4'hB
`define TAP_EXIT1_IR   4'hC
`define TAP_PAUSE_IR   4'hD
`define TAP_EXIT2_IR   4'hE
`define TAP_UPD_IR     4'hF
`define PST_HALTED     4'hF
`define PST_RESET_C    4'hC
`define PST_RESET_D    4'hD
`define IR_CAPTURE     4'h1
`define IR_RESET       4'hF
`define TRACE_DIV      2'h1
`endif

// file: src/trace_fifo.v
`default_nettype none
module trace_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter AW    = 3
)(
	// Clock and reset.
	input  wire             ref_clk,
	input  wire             arst_n,
	// Fill side.
	input  wire [WIDTH-1:0] in_data,
	input  wire             in_valid,
	output wire             in_ready,
	// Drain side.
	output wire [WIDTH-1:0] out_data,
	output wire             out_valid,
	input  wire             out_ready
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_reg;
	reg [AW-1:0]    rd_reg;
	reg [AW:0]      cnt_reg;
	wire            push;
	wire            pop;
	assign in_ready  = (cnt_reg != DEPTH[AW:0]);
	assign out_valid = (cnt_reg != {(AW+1){1'b0}});
	assign out_data  = mem[rd_reg];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	always @(posedge ref_clk)
	begin
		if (push)
			mem[wr_reg] <= in_data;
	end
	always @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wr_reg  <= {AW{1'b0}};
			rd_reg  <= {AW{1'b0}};
			cnt_reg <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wr_reg <= (wr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_reg + 1'b1;
			if (pop)
				rd_reg <= (rd_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_reg + 1'b1;
			if (push & ~pop)
				cnt_reg <= cnt_reg + 1'b1;
			else if (pop & ~push)
				cnt_reg <= cnt_reg - 1'b1;
		end
	end
endmodule
`default_nettype wire

// file: src/debug_jtag_trace_port.v
// Notes on behaviour
// R1: Select pin at reset picks debug or scan.
// R2: Test reset clears scan logic asynchronously; code synchronises it to ref_clk and clears synchronously.
// R3: Mode select sampled on rising test clock.
// R4: Test data in sampled on rising edge.
// R5: Test data out driven only in shifts.
// R6: Test data out updates on falling edge.
// R7: Serial clock accepted after two equal samples.
// R8: Debugger keeps serial clock below status/5.
// R9: Synchronized rising edge samples in, shifts out.
// R10: Serial input valid after clock seen high.
// R11: Serial out registered, lags clock validation.
// R12: Halt request halts after current instruction.
// R13: Halted core shows status 0xF.
// R14: Disable bit turns halt into debug interrupt.
// R15: Trace clock rises mid status interval.
// R16: Clock-disable bit freezes trace outputs only.
// R17: Host resynchronizes after clock re-enable.
// R18: Trace clock starts at first C/D/F status.
// R19: Combined status is AND of bits.
// R20: Trace data shows captured data, breakpoints.
// R21: Status follows core, not bus transfers.
// R22: Standard sixteen-state controller, reset on test reset.
`include "debug_port_defs.vh"
`default_nettype none
module debug_jtag_trace_port #(
	parameter IR_LEN   = 4,
	parameter DBG_LEN  = 17,
	parameter FIFO_DEP = 8
)(
	// Clock and reset.
	input  wire               ref_clk,
	input  wire               arst_n,
	// Mode select strap.
	input  wire               scan_select,
	output wire               scan_mode,
	// Boundary scan pins.
	input  wire               test_reset_n,
	input  wire               test_clk,
	input  wire               test_mode_sel,
	input  wire               test_data_in,
	output wire               test_data_out,
	output wire               test_data_out_oe,
	// Debug serial pins.
	input  wire               dbg_serial_clk,
	input  wire               dbg_serial_in,
	output wire               dbg_serial_out,
	// Debug packets to and from the core.
	output reg  [DBG_LEN-1:0] dbg_rx_word,
	output reg                dbg_rx_valid,
	input  wire [DBG_LEN-1:0] dbg_tx_word,
	input  wire               dbg_tx_load,
	// Breakpoint request.
	input  wire               halt_request,
	input  wire               halt_request_disable,
	input  wire               instr_done,
	input  wire               resume,
	output reg                core_halted,
	output reg                debug_irq,
	// Core status and trace source.
	input  wire [3:0]         core_status_in,
	input  wire [3:0]         trace_data_in,
	input  wire               trace_in_valid,
	output wire               trace_in_ready,
	input  wire               trace_clock_disable,
	// Trace pins.
	output reg  [3:0]         core_status_out,
	output reg  [3:0]         trace_data_out,
	output reg                trace_clock,
	output wire               status_all_and,
	output reg                system_clock_out
);
	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	reg  [1:0] tck_s_reg;
	reg  [1:0] trst_s_reg;
	reg  [1:0] tms_s_reg;
	reg  [1:0] tdi_s_reg;
	reg  [1:0] dclk_s_reg;
	reg  [1:0] dsi_s_reg;
	reg  [1:0] brk_s_reg;
	reg        tck_d_reg;
	always @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tck_s_reg  <= 2'h0;
			trst_s_reg <= 2'h0;
			tms_s_reg  <= 2'h3;
			tdi_s_reg  <= 2'h0;
			dclk_s_reg <= 2'h0;
			dsi_s_reg  <= 2'h0;
			brk_s_reg  <= 2'h0;
			tck_d_reg  <= 1'b0;
		end
		else
		begin
			tck_s_reg  <= {tck_s_reg[0], test_clk};
			trst_s_reg <= {trst_s_reg[0], test_reset_n};
			tms_s_reg  <= {tms_s_reg[0], test_mode_sel};
			tdi_s_reg  <= {tdi_s_reg[0], test_data_in};
			dclk_s_reg <= {dclk_s_reg[0], dbg_serial_clk};
			dsi_s_reg  <= {dsi_s_reg[0], dbg_serial_in};
			brk_s_reg  <= {brk_s_reg[0], halt_request};
			tck_d_reg  <= tck_s_reg[1];
		end
	end
	wire tck_rise = tck_s_reg[1] & ~tck_d_reg;
	wire tck_fall = ~tck_s_reg[1] & tck_d_reg;

	// ---------------------------------------------------------------
	// Mode strap
	// ---------------------------------------------------------------
	reg strap_done_reg;
	reg scan_mode_reg;
	assign scan_mode = scan_mode_reg;
	always @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			strap_done_reg <= 1'b0;
			scan_mode_reg  <= 1'b0;
		end
		else if (!strap_done_reg)
		begin
			strap_done_reg <= 1'b1;
			scan_mode_reg  <= scan_select; // see R1
		end
	end

	// ---------------------------------------------------------------
	// Test access port
	// ---------------------------------------------------------------
	reg  [3:0]        tap_reg;
	reg  [3:0]        tap_next;
	reg  [IR_LEN-1:0] ir_sh_reg;
	reg  [IR_LEN-1:0] ir_reg;
	reg               bypass_reg;
	reg               tdo_reg;
	wire              tms = tms_s_reg[1];
	wire              trst_n = trst_s_reg[1] & scan_mode_reg;
	always @*
	begin
		case (tap_reg) // see R22
		`TAP_RESET:    tap_next = tms ? `TAP_RESET : `TAP_IDLE;
		`TAP_IDLE:     tap_next = tms ? `TAP_SEL_DR : `TAP_IDLE;
		`TAP_SEL_DR:   tap_next = tms ? `TAP_SEL_IR : `TAP_CAP_DR;
		`TAP_CAP_DR:   tap_next = tms ? `TAP_EXIT1_DR : `TAP_SHIFT_DR;
		`TAP_SHIFT_DR: tap_next = tms ? `TAP_EXIT1_DR : `TAP_SHIFT_DR;
		`TAP_EXIT1_DR: tap_next = tms ? `TAP_UPD_DR : `TAP_PAUSE_DR;
		`TAP_PAUSE_DR: tap_next = tms ? `TAP_EXIT2_DR : `TAP_PAUSE_DR;
		`TAP_EXIT2_DR: tap_next = tms ? `TAP_UPD_DR : `TAP_SHIFT_DR;
		`TAP_UPD_DR:   tap_next = tms ? `TAP_SEL_DR : `TAP_IDLE;
		`TAP_SEL_IR:   tap_next = tms ? `TAP_RESET : `TAP_CAP_IR;
		`TAP_CAP_IR:   tap_next = tms ? `TAP_EXIT1_IR : `TAP_SHIFT_IR;
		`TAP_SHIFT_IR: tap_next = tms ? `TAP_EXIT1_IR : `TAP_SHIFT_IR;
		`TAP_EXIT1_IR: tap_next = tms ? `TAP_UPD_IR : `TAP_PAUSE_IR;
		`TAP_PAUSE_IR: tap_next = tms ? `TAP_EXIT2_IR : `TAP_PAUSE_IR;
		`TAP_EXIT2_IR: tap_next = tms ? `TAP_UPD_IR : `TAP_SHIFT_IR;
		`TAP_UPD_IR:   tap_next = tms ? `TAP_SEL_DR : `TAP_IDLE;
		default:       tap_next = `TAP_RESET;
		endcase
	end
	// The synchronised test reset acts at once, whatever the test clock does.
	always @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tap_reg    <= `TAP_RESET;
			ir_sh_reg  <= {IR_LEN{1'b0}};
			ir_reg     <= `IR_RESET;
			bypass_reg <= 1'b0;
			tdo_reg    <= 1'b0;
		end
		else if (!trst_n)
		begin
			tap_reg <= `TAP_RESET; // see R2, R22
			ir_reg  <= `IR_RESET;
		end
		else
		begin
			if (tck_rise)
			begin
				tap_reg <= tap_next; // see R3
				if (tap_reg == `TAP_CAP_IR)
					ir_sh_reg <= `IR_CAPTURE;
				else if (tap_reg == `TAP_SHIFT_IR)
					ir_sh_reg <= {tdi_s_reg[1], ir_sh_reg[IR_LEN-1:1]}; // see R4
				if (tap_reg == `TAP_UPD_IR)
					ir_reg <= ir_sh_reg;
				else if (tap_reg == `TAP_RESET)
					ir_reg <= `IR_RESET;
				if (tap_reg == `TAP_CAP_DR)
					bypass_reg <= 1'b0;
				else if (tap_reg == `TAP_SHIFT_DR)
					bypass_reg <= tdi_s_reg[1]; // see R4
			end
			if (tck_fall)
				tdo_reg <= (tap_reg == `TAP_SHIFT_IR) ? ir_sh_reg[0] : bypass_reg; // see R6
		end
	end
	reg tdo_oe_reg;
	always @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			tdo_oe_reg <= 1'b0;
		else if (!trst_n)
			tdo_oe_reg <= 1'b0;
		else if (tck_fall)
			tdo_oe_reg <= (tap_reg == `TAP_SHIFT_IR) || (tap_reg == `TAP_SHIFT_DR); // see R5
	end
	assign test_data_out    = tdo_reg;
	assign test_data_out_oe = tdo_oe_reg;

	// ---------------------------------------------------------------
	// Debug serial port
	// ---------------------------------------------------------------
	reg                dclk_val_reg;
	reg                dclk_prev_reg;
	reg                dclk_up_reg;
	reg  [DBG_LEN-1:0] rx_sh_reg;
	reg  [DBG_LEN-1:0] tx_sh_reg;
	reg  [4:0]         bit_cnt_reg;
	reg                dso_reg;
	assign dbg_serial_out = dso_reg;
	always @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			dclk_val_reg  <= 1'b0;
			dclk_prev_reg <= 1'b0;
			dclk_up_reg   <= 1'b0;
			rx_sh_reg     <= {DBG_LEN{1'b0}};
			tx_sh_reg     <= {DBG_LEN{1'b0}};
			bit_cnt_reg   <= 5'h0;
			dso_reg       <= 1'b0;
			dbg_rx_word   <= {DBG_LEN{1'b0}};
			dbg_rx_valid  <= 1'b0;
		end
		else
		begin
			dbg_rx_valid <= 1'b0;
			if (dclk_s_reg[1] == dclk_prev_reg)
				dclk_val_reg <= dclk_s_reg[1]; // see R7
			dclk_prev_reg <= dclk_s_reg[1];
			dclk_up_reg   <= dclk_s_reg[1] & (dclk_s_reg[1] == dclk_prev_reg) & ~dclk_val_reg;
			if (dbg_tx_load && !scan_mode_reg)
				tx_sh_reg <= dbg_tx_word;
			if (dclk_up_reg && !scan_mode_reg)
			begin
				rx_sh_reg <= {rx_sh_reg[DBG_LEN-2:0], dsi_s_reg[1]}; // see R9, R10
				dso_reg   <= tx_sh_reg[DBG_LEN-1]; // see R11
				tx_sh_reg <= {tx_sh_reg[DBG_LEN-2:0], 1'b0};
				if (bit_cnt_reg == DBG_LEN[4:0] - 5'h1)
				begin
					bit_cnt_reg  <= 5'h0;
					dbg_rx_word  <= {rx_sh_reg[DBG_LEN-2:0], dsi_s_reg[1]};
					dbg_rx_valid <= 1'b1;
				end
				else
					bit_cnt_reg <= bit_cnt_reg + 5'h1;
			end
		end
	end

	// ---------------------------------------------------------------
	// Breakpoint request
	// ---------------------------------------------------------------
	reg  brk_pend_reg;
	reg  brk_d_reg;
	// A held request is taken once, so it cannot halt the core again after resume.
	wire brk_rise = brk_s_reg[1] & ~brk_d_reg;
	always @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			brk_pend_reg <= 1'b0;
			brk_d_reg    <= 1'b0;
			core_halted  <= 1'b0;
			debug_irq    <= 1'b0;
		end
		else
		begin
			debug_irq <= 1'b0;
			brk_d_reg <= brk_s_reg[1];
			if (brk_s_reg[1] && !scan_mode_reg && halt_request_disable)
				debug_irq <= 1'b1; // see R14
			if (brk_rise && !scan_mode_reg && !halt_request_disable)
				brk_pend_reg <= 1'b1;
			else if (instr_done)
				brk_pend_reg <= 1'b0;
			if (brk_pend_reg && instr_done)
				core_halted <= 1'b1; // see R12
			else if (resume)
				core_halted <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Status and trace output
	// ---------------------------------------------------------------
	reg  [1:0] phase_reg;
	reg        trace_run_reg;
	wire [3:0] fifo_data;
	wire       fifo_valid;
	wire       step = (phase_reg == 2'h3);
	wire [3:0] status_now = core_halted ? `PST_HALTED : core_status_in; // see R13, R21
	trace_fifo #(
		.WIDTH (4),
		.DEPTH (FIFO_DEP),
		.AW    (3)
	) u_fifo (
		.ref_clk   (ref_clk),
		.arst_n    (arst_n),
		.in_data   (trace_data_in),
		.in_valid  (trace_in_valid),
		.in_ready  (trace_in_ready),
		.out_data  (fifo_data),
		.out_valid (fifo_valid),
		.out_ready (step & ~trace_clock_disable)
	);
	// Outputs change on phase 3; the trace clock rises on phase 1, mid interval.
	always @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			phase_reg        <= 2'h0;
			trace_run_reg    <= 1'b0;
			core_status_out  <= 4'h0;
			trace_data_out   <= 4'h0;
			trace_clock      <= 1'b0;
			system_clock_out <= 1'b0;
		end
		else
		begin
			phase_reg        <= phase_reg + 2'h1;
			system_clock_out <= phase_reg[1];
			if (status_now == `PST_RESET_C || status_now == `PST_RESET_D || status_now == `PST_HALTED)
				trace_run_reg <= 1'b1; // see R18
			if (!trace_clock_disable) // see R16
			begin
				if (step)
				begin
					core_status_out <= status_now;
					if (fifo_valid)
						trace_data_out <= fifo_data; // see R20
				end
				if (phase_reg == `TRACE_DIV)
					trace_clock <= trace_run_reg; // see R15
				else if (step)
					trace_clock <= 1'b0;
			end
		end
	end
	assign status_all_and = &core_status_out; // see R19
endmodule
`default_nettype wire

// file: verif/debug_jtag_trace_port_checker.sv
`default_nettype none
module dbg_port_checker (
	// Clock and reset.
	input wire logic       ref_clk,
	input wire logic       arst_n,
	// Scan side.
	input wire logic       scan_mode,
	input wire logic       test_clk,
	input wire logic       test_data_out,
	input wire logic       test_data_out_oe,
	// Debug serial and halt.
	input wire logic       dbg_serial_clk,
	input wire logic       dbg_serial_out,
	input wire logic       dbg_tx_load,
	input wire logic       dbg_rx_valid,
	input wire logic       halt_request_disable,
	input wire logic       instr_done,
	input wire logic       core_halted,
	input wire logic       debug_irq,
	// Trace side.
	input wire logic       trace_clock_disable,
	input wire logic [3:0] core_status_out,
	input wire logic [3:0] trace_data_out,
	input wire logic       trace_clock,
	input wire logic       status_all_and
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);
	a_and_status: assert property (status_all_and == &core_status_out)
		else $error("combined status differs");
	a_oe_debug_mode: assert property (!scan_mode |-> !test_data_out_oe)
		else $error("scan output driven in debug mode");
	a_tdo_after_fall: assert property ($changed(test_data_out) && test_data_out_oe |-> !$past(test_clk, 2))
		else $error("scan output moved outside low phase");
	a_dso_after_high: assert property
		($changed(dbg_serial_out) |-> $past(dbg_serial_clk, 2) || $past(dbg_tx_load) || $past(dbg_tx_load, 2))
		else $error("serial output moved without validated clock");
	a_halt_after_done: assert property ($rose(core_halted) |-> $past(instr_done))
		else $error("halt without instruction end");
	a_irq_only_disabled: assert property (debug_irq |-> $past(halt_request_disable))
		else $error("debug interrupt while halting enabled");
	a_trace_frozen: assert property (trace_clock_disable [*5] |-> $stable(trace_clock) && $stable(core_status_out))
		else $error("trace moved while disabled");
	a_trace_period: assert property (disable iff (!arst_n || trace_clock_disable)
		$rose(trace_clock) |=> trace_clock ##1 !trace_clock ##1 !trace_clock ##1 trace_clock)
		else $error("trace clock shape wrong");
	a_status_mid_clock: assert property
		($changed(core_status_out) || $changed(trace_data_out) |-> !trace_clock)
		else $error("trace outputs moved while clock high");
	c_halt: cover property ($rose(core_halted));
	c_irq: cover property ($rose(debug_irq));
	c_rx: cover property (dbg_rx_valid);
	c_shift: cover property ($rose(test_data_out_oe));
endmodule
bind debug_jtag_trace_port dbg_port_checker chk (.ref_clk, .arst_n, .scan_mode, .test_clk, .test_data_out,
	.test_data_out_oe, .dbg_serial_clk, .dbg_serial_out, .dbg_tx_load, .dbg_rx_valid, .halt_request_disable,
	.instr_done, .core_halted, .debug_irq, .trace_clock_disable, .core_status_out, .trace_data_out,
	.trace_clock, .status_all_and);
`default_nettype wire

// file: verif/probe_model.sv
`default_nettype none
module probe_model #(
	parameter int LEN = 17
)(
	// Clock.
	input  wire logic ref_clk,
	// Scan pins.
	output var logic  test_reset_n,
	output var logic  test_clk,
	output var logic  test_mode_sel,
	output var logic  test_data_in,
	input  wire logic test_data_out,
	input  wire logic test_data_out_oe,
	// Debug serial pins.
	output var logic  dbg_serial_clk,
	output var logic  dbg_serial_in,
	input  wire logic dbg_serial_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		test_reset_n = 1'b0;
		test_clk = 1'b0;
		test_mode_sel = 1'b1;
		test_data_in = 1'b0;
		dbg_serial_clk = 1'b0;
		dbg_serial_in = 1'b0;
	end
	// One test clock of 32 ref_clk cycles (160 ns); output sampled 8 cycles into the low phase.
	task automatic tck(input logic tms, output logic tdo, output logic oe);
		@(negedge ref_clk);
		test_mode_sel = tms;
		test_data_in = 1'($urandom);
		repeat (7) @(negedge ref_clk);
		test_clk = 1'b1;
		repeat (16) @(negedge ref_clk);
		test_clk = 1'b0;
		repeat (8) @(negedge ref_clk);
		tdo = test_data_out;
		oe = test_data_out_oe;
	endtask
	// Serial clock of 160 ns, well under the trace rate divided by five.
	task automatic serial_frame(input logic [LEN-1:0] tx, output logic [LEN-1:0] rx);
		for (int i = LEN - 1; i >= 0; i--)
		begin
			dbg_serial_in = tx[i];
			repeat (16) @(negedge ref_clk);
			dbg_serial_clk = 1'b1;
			repeat (16) @(negedge ref_clk);
			rx[i] = dbg_serial_out;
			dbg_serial_clk = 1'b0;
		end
		dbg_serial_in = ~dbg_serial_in;
	endtask
endmodule
`default_nettype wire

// file: verif/debug_jtag_trace_port_tb.sv
`default_nettype none
module debug_jtag_trace_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int         DL = 17;
	localparam logic [4:0] WALK = 5'b00110;
	localparam logic [3:0] CODES [3] = '{4'hC, 4'hD, 4'hF};
	logic          ref_clk = 1'b0, arst_n = 1'b0, scan_select = 1'b0, trace_in_valid = 1'b0, resume = 1'b0;
	logic          halt_request = 1'b0, halt_request_disable = 1'b0, instr_done = 1'b0, dbg_tx_load = 1'b0;
	logic          trace_clock_disable = 1'b0;
	logic [3:0]    core_status_in = 4'h0, trace_data_in = 4'h0;
	logic [DL-1:0] dbg_tx_word = '0, rx_cap = '0;
	logic [3:0]    seen[$];
	int            bad_count = 0, n_checks = 0, n_rise = 0, n_rx = 0, n_sys = 0;
	wire           scan_mode, test_reset_n, test_clk, test_mode_sel, test_data_in, test_data_out;
	wire           test_data_out_oe, dbg_serial_clk, dbg_serial_in, dbg_serial_out, dbg_rx_valid;
	wire           core_halted, debug_irq, trace_in_ready, trace_clock, status_all_and, system_clock_out;
	wire [3:0]     core_status_out, trace_data_out;
	wire [DL-1:0]  dbg_rx_word;
	debug_jtag_trace_port #(.DBG_LEN(DL)) DUT (.ref_clk, .arst_n, .scan_select, .scan_mode, .test_reset_n,
		.test_clk, .test_mode_sel, .test_data_in, .test_data_out, .test_data_out_oe, .dbg_serial_clk,
		.dbg_serial_in, .dbg_serial_out, .dbg_rx_word, .dbg_rx_valid, .dbg_tx_word, .dbg_tx_load,
		.halt_request, .halt_request_disable, .instr_done, .resume, .core_halted, .debug_irq,
		.core_status_in, .trace_data_in, .trace_in_valid, .trace_in_ready, .trace_clock_disable,
		.core_status_out, .trace_data_out, .trace_clock, .status_all_and, .system_clock_out);
	probe_model #(.LEN(DL)) p (.ref_clk, .test_reset_n, .test_clk, .test_mode_sel, .test_data_in,
		.test_data_out, .test_data_out_oe, .dbg_serial_clk, .dbg_serial_in, .dbg_serial_out);
	always #2.5 ref_clk = ~ref_clk;
	always @(posedge trace_clock)
	begin
		n_rise++;
		seen.push_back(trace_data_out);
	end
	always @(posedge system_clock_out)
		n_sys++;
	always @(negedge ref_clk)
		if (dbg_rx_valid === 1'b1)
		begin
			n_rx++;
			rx_cap = dbg_rx_word;
		end
	function automatic logic [3:0] exp_status(input logic halted, input logic [3:0] core);
		return halted ? 4'hF : core;
	endfunction
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
		n_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask
	task automatic end_sim();
		if (bad_count == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic do_reset(input logic sel);
		arst_n = 1'b0;
		scan_select = sel;
		repeat (12) @(negedge ref_clk);
		arst_n = 1'b1;
		repeat (3) @(negedge ref_clk);
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		@(negedge ref_clk);
		s = 1'b0;
	endtask
	initial
	begin
		#100000;
		bad_count++;
		end_sim();
	end
	// ------------------------------------------------------------
	// Main sequence.
	// ------------------------------------------------------------
	initial
	begin
		logic [DL-1:0] rx, got_w;
		logic [3:0]    q[$], got;
		logic          tdo, oe, acc;
		int            idx, n0, full, ns0;
		void'($urandom(36));
		do_reset(1'b0);
		check(scan_mode, 0, "strap debug");
		for (int k = 0; k < 5; k++)
		begin
			p.tck(WALK[k], tdo, oe);
			check(oe, 0, "scan active in debug mode");
		end
		for (int c = 0; c < 3; c++)
		begin
			core_status_in = 4'h0;
			do_reset(1'b0);
			n0 = n_rise;
			repeat (40) @(negedge ref_clk);
			check(n_rise, n0, "trace clock before status");
			core_status_in = CODES[c];
			repeat (40) @(negedge ref_clk);
			check(n_rise > n0 + 6, 1, "trace clock not started");
		end
		seen.delete();
		full = 0;
		trace_in_valid = 1'b1;
		repeat (24)
		begin
			trace_data_in = 4'($urandom);
			acc = trace_in_ready;
			full += !trace_in_ready;
			@(negedge ref_clk);
			if (acc)
				q.push_back(trace_data_in);
		end
		trace_in_valid = 1'b0;
		check(full > 0, 1, "buffer never refused");
		ns0 = n_sys;
		repeat (120) @(negedge ref_clk);
		check(n_sys, ns0 + 30, "system clock rate");
		idx = 0;
		foreach (seen[i])
			if (idx < q.size() && seen[i] === q[idx])
				idx++;
		check(idx, q.size(), "trace data order");
		core_status_in = 4'($urandom % 12);
		halt_request = 1'b1;
		repeat (10) @(negedge ref_clk);
		check(core_halted, 0, "halt before instruction end");
		pulse(instr_done);
		repeat (4) if (core_halted !== 1'b1) @(negedge ref_clk);
		check(core_halted, 1, "no halt");
		repeat (12) @(negedge ref_clk);
		check(core_status_out, exp_status(1'b1, core_status_in), "halt status");
		check(status_all_and, 1, "combined status");
		halt_request = 1'b0;
		pulse(resume);
		repeat (12) @(negedge ref_clk);
		check(core_status_out, exp_status(1'b0, core_status_in), "running status");
		halt_request_disable = 1'b1;
		@(negedge ref_clk);
		halt_request = 1'b1;
		repeat (6) @(negedge ref_clk);
		check(debug_irq, 1, "no debug interrupt");
		pulse(instr_done);
		repeat (4) @(negedge ref_clk);
		check(core_halted, 0, "halted while disabled");
		halt_request = 1'b0;
		repeat (6) @(negedge ref_clk);
		halt_request_disable = 1'b0;
		trace_clock_disable = 1'b1;
		repeat (4) @(negedge ref_clk);
		n0 = n_rise;
		repeat (40) @(negedge ref_clk);
		check(n_rise, n0, "trace clock not frozen");
		trace_clock_disable = 1'b0;
		repeat (40) @(negedge ref_clk);
		check(n_rise > n0 + 6, 1, "trace clock not resumed");
		for (int f = 0; f < 2; f++)
		begin
			dbg_tx_word = f ? DL'($urandom) : '1;
			pulse(dbg_tx_load);
			rx = f ? DL'($urandom) : '0;
			n0 = n_rx;
			p.serial_frame(rx, got_w);
			check(got_w, dbg_tx_word, "serial out word");
			check(n_rx, n0 + 1, "serial frame count");
			check(rx_cap, rx, "serial in word");
		end
		do_reset(1'b1);
		check(scan_mode, 1, "strap scan");
		for (int r = 0; r < 2; r++)
		begin
			p.test_reset_n = 1'b1;
			for (int k = 0; k < 5; k++)
				p.tck(WALK[k], got[0], oe);
			check(oe, 1, "not driving in shift");
			for (int k = 1; k < 4; k++)
				p.tck(1'b0, got[k], oe);
			check(got, 4'h1, "capture pattern");
			if (r == 0)
			begin
				p.tck(1'b1, tdo, oe);
				check(oe, 0, "driving outside shift");
			end
			p.test_reset_n = 1'b0;
			repeat (8) @(negedge ref_clk);
			check(test_data_out_oe, 0, "test reset ignored");
		end
		end_sim();
	end
endmodule
`default_nettype wire
